//--- pkg/bmac_defs.vh
// constants for the booth multiply-accumulate unit
`ifndef BMAC_DEFS_VH
`define BMAC_DEFS_VH

// ****************************************************************
// apb register map (byte addresses)
// ****************************************************************
`define BMAC_ADDR_W 8
`define BMAC_OFF_INSTR 8'h00
`define BMAC_OFF_FLAGS 8'h04
`define BMAC_OFF_STATUS 8'h08
`define BMAC_OFF_RESULT 8'h0c
`define BMAC_OFF_RF_BASE 8'h40
`define BMAC_RF_HI 7
`define BMAC_RF_LO 6
`define BMAC_RF_SEL 2'b01
`define BMAC_RF_IDX_HI 5
`define BMAC_RF_IDX_LO 2

// ****************************************************************
// instruction fields
// ****************************************************************
`define BMAC_F_COND_HI 31
`define BMAC_F_COND_LO 28
`define BMAC_F_ZERO_HI 27
`define BMAC_F_ZERO_LO 22
`define BMAC_F_ACC 21
`define BMAC_F_SET 20
`define BMAC_F_RD_HI 19
`define BMAC_F_RD_LO 16
`define BMAC_F_RN_HI 15
`define BMAC_F_RN_LO 12
`define BMAC_F_RS_HI 11
`define BMAC_F_RS_LO 8
`define BMAC_F_TAG_HI 7
`define BMAC_F_TAG_LO 4
`define BMAC_F_RM_HI 3
`define BMAC_F_RM_LO 0
`define BMAC_TAG_MUL 4'h9
`define BMAC_ZERO_FIELD 6'h00
`define BMAC_PC_IDX 4'hf

// ****************************************************************
// status word, flag word and reset values
// ****************************************************************
`define BMAC_FLAG_N 3
`define BMAC_FLAG_Z 2
`define BMAC_FLAG_C 1
`define BMAC_FLAG_V 0
`define BMAC_FLAGS_POS_HI 31
`define BMAC_FLAGS_POS_LO 28
`define BMAC_FLAGS_RST 4'h0
`define BMAC_ST_BUSY 0
`define BMAC_ST_EXEC 1
`define BMAC_ST_REFUSED 2
`define BMAC_ST_M_HI 12
`define BMAC_ST_M_LO 8

// ****************************************************************
// condition codes and timing
// ****************************************************************
`define BMAC_CC_EQ 4'h0
`define BMAC_CC_NE 4'h1
`define BMAC_CC_CS 4'h2
`define BMAC_CC_CC 4'h3
`define BMAC_CC_MI 4'h4
`define BMAC_CC_PL 4'h5
`define BMAC_CC_VS 4'h6
`define BMAC_CC_VC 4'h7
`define BMAC_CC_HI 4'h8
`define BMAC_CC_LS 4'h9
`define BMAC_CC_GE 4'ha
`define BMAC_CC_LT 4'hb
`define BMAC_CC_GT 4'hc
`define BMAC_CC_LE 4'hd
`define BMAC_CC_AL 4'he
`define BMAC_MAX_STEPS 5'h10
`define BMAC_MIN_STEPS 5'h01

`endif

//--- rtl/bmac_booth_step.v
// one radix-4 booth recoding step: acc plus digit times multiplicand
`timescale 1ns/100ps
`default_nettype none
`include "bmac_defs.vh"

module bmac_booth_step #(
    parameter WIDTH = 32
) (
    input wire [WIDTH-1:0] acc,
    input wire [WIDTH-1:0] mcand,
    input wire [2:0] triplet,
    output wire [WIDTH-1:0] sum,
    output wire carry
);
    reg [WIDTH-1:0] pp;
    reg neg;
    wire [WIDTH:0] full;

    // digit in {-2,-1,0,+1,+2}; only low bits kept, so sign is free
    always @* begin
        case (triplet)
            3'h1, 3'h2: begin
                pp = mcand;
                neg = 1'b0;
            end
            3'h3: begin
                pp = {mcand[WIDTH-2:0], 1'b0};
                neg = 1'b0;
            end
            3'h4: begin
                pp = {mcand[WIDTH-2:0], 1'b0};
                neg = 1'b1;
            end
            3'h5, 3'h6: begin
                pp = mcand;
                neg = 1'b1;
            end
            default: begin
                pp = {WIDTH{1'b0}};
                neg = 1'b0;
            end
        endcase
    end

    assign full = {1'b0, acc} + {1'b0, (neg ? ~pp : pp)} + {{WIDTH{1'b0}}, neg};
    assign sum = full[WIDTH-1:0];
    assign carry = full[WIDTH];
endmodule // bmac_booth_step
`default_nettype wire

//--- rtl/bmac_cond_check.v
// condition field evaluation against the current flags
`timescale 1ns/100ps
`default_nettype none
`include "bmac_defs.vh"

module bmac_cond_check (
    input wire [3:0] cond,
    input wire [3:0] flags,
    output reg pass
);
    wire n = flags[`BMAC_FLAG_N];
    wire z = flags[`BMAC_FLAG_Z];
    wire c = flags[`BMAC_FLAG_C];
    wire v = flags[`BMAC_FLAG_V];

    // never-code 4'hf falls to default: no execution
    always @* begin
        case (cond)
            `BMAC_CC_EQ: pass = z;
            `BMAC_CC_NE: pass = ~z;
            `BMAC_CC_CS: pass = c;
            `BMAC_CC_CC: pass = ~c;
            `BMAC_CC_MI: pass = n;
            `BMAC_CC_PL: pass = ~n;
            `BMAC_CC_VS: pass = v;
            `BMAC_CC_VC: pass = ~v;
            `BMAC_CC_HI: pass = c & ~z;
            `BMAC_CC_LS: pass = ~c | z;
            `BMAC_CC_GE: pass = (n == v);
            `BMAC_CC_LT: pass = (n != v);
            `BMAC_CC_GT: pass = ~z & (n == v);
            `BMAC_CC_LE: pass = z | (n != v);
            `BMAC_CC_AL: pass = 1'b1;
            default: pass = 1'b0;
        endcase
    end
endmodule // bmac_cond_check
`default_nettype wire

//--- rtl/bmac_top.v
// booth multiply-accumulate unit with apb register access
`timescale 1ns/100ps
`default_nettype none
`include "bmac_defs.vh"

// Operation
// - executes and writes only if condition passes
// - radix-4 booth, low 32 product bits
// - plain multiply: first operand times multiplier
// - multiply-add adds accumulate source, 32-bit wrap
// - one datapath serves signed and unsigned
// - dest equals first operand: multiply gives zero
// - all other register combinations correct
// - flags change only with set-flags bit
// - negative is bit 31, zero on zero
// - carry meaningless, overflow kept
// - one fetch cycle plus m internal cycles
// - m from multiplier magnitude, two to sixteen
// - multiplier zero or one: one internal cycle
// - at most sixteen internal cycles

module bmac_top #(
    parameter WIDTH = 32,
    parameter NREGS = 16
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`BMAC_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg pipe_stall,
    output reg mul_done
);
    // ****************************************************************
    // states
    // ****************************************************************
    localparam ST_IDLE = 2'b00;
    localparam ST_FETCH = 2'b01;
    localparam ST_CALC = 2'b10;

    // ****************************************************************
    // functions
    // ****************************************************************
    function is_rf;
        input [`BMAC_ADDR_W-1:0] a;
        begin
            is_rf = (a[`BMAC_RF_HI:`BMAC_RF_LO] == `BMAC_RF_SEL);
        end
    endfunction

    // internal cycles needed for a multiplier value
    function [4:0] steps_for;
        input [31:0] v;
        integer i;
        reg [5:0] h;
        reg [5:0] m;
        begin
            h = 6'h00;
            for (i = 0; i < 32; i = i + 1) begin
                if (v[i]) begin
                    h = i[5:0];
                end
            end
            m = ((h + 6'h01) >> 1) + 6'h01;
            if (v[31:1] == 31'h0) begin
                steps_for = `BMAC_MIN_STEPS;
            end else if (m > {1'b0, `BMAC_MAX_STEPS}) begin
                steps_for = `BMAC_MAX_STEPS;
            end else begin
                steps_for = m[4:0];
            end
        end
    endfunction

    function names_pc;
        input [31:0] w;
        begin
            names_pc = (w[`BMAC_F_RD_HI:`BMAC_F_RD_LO] == `BMAC_PC_IDX)
                | (w[`BMAC_F_RS_HI:`BMAC_F_RS_LO] == `BMAC_PC_IDX)
                | (w[`BMAC_F_RM_HI:`BMAC_F_RM_LO] == `BMAC_PC_IDX)
                | (w[`BMAC_F_ACC]
                   & (w[`BMAC_F_RN_HI:`BMAC_F_RN_LO] == `BMAC_PC_IDX));
        end
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    reg [WIDTH-1:0] rf_q [0:NREGS-1];
    reg [1:0] state_q;
    reg [31:0] instr_q;
    reg [3:0] flags_q;
    reg [WIDTH-1:0] acc_q;
    reg [WIDTH-1:0] mcand_q;
    reg [WIDTH-1:0] mplr_q;
    reg prev_q;
    reg [4:0] cnt_q;
    reg [4:0] m_q;
    reg force_zero_q;
    reg exec_q;
    reg refused_q;
    reg [WIDTH-1:0] result_q;
    reg wb_en_q;
    reg [3:0] wb_idx_q;

    // ****************************************************************
    // apb decode
    // ****************************************************************
    wire acc_ph = psel & penable & ~pready;
    wire wr = acc_ph & pwrite;
    wire rd = acc_ph & ~pwrite;
    wire rf_hit = is_rf(paddr);
    wire [3:0] rf_idx = paddr[`BMAC_RF_IDX_HI:`BMAC_RF_IDX_LO];
    wire busy = (state_q != ST_IDLE);
    wire hit_instr = (paddr == `BMAC_OFF_INSTR);
    wire hit_flags = (paddr == `BMAC_OFF_FLAGS);
    wire hit_status = (paddr == `BMAC_OFF_STATUS);
    wire hit_result = (paddr == `BMAC_OFF_RESULT);

    // a word that does not carry the multiply marker is refused
    wire enc_ok = (pwdata[`BMAC_F_ZERO_HI:`BMAC_F_ZERO_LO]
                   == `BMAC_ZERO_FIELD)
                  & (pwdata[`BMAC_F_TAG_HI:`BMAC_F_TAG_LO]
                   == `BMAC_TAG_MUL);
    // the unit leans on the issuer here, but refuses rather than
    // produce a garbage pc write
    wire pc_bad = names_pc(pwdata);
    wire issue = wr & hit_instr & ~busy & enc_ok & ~pc_bad;

    wire wr_err = (hit_instr & (busy | ~enc_ok | pc_bad))
                  | ((hit_flags | rf_hit) & busy)
                  | hit_status | hit_result
                  | ~(hit_instr | hit_flags | rf_hit);
    wire rd_err = ~(hit_instr | hit_flags | hit_status | hit_result
                    | rf_hit);

    wire [3:0] i_rd = pwdata[`BMAC_F_RD_HI:`BMAC_F_RD_LO];
    wire [3:0] i_rn = pwdata[`BMAC_F_RN_HI:`BMAC_F_RN_LO];
    wire [3:0] i_rs = pwdata[`BMAC_F_RS_HI:`BMAC_F_RS_LO];
    wire [3:0] i_rm = pwdata[`BMAC_F_RM_HI:`BMAC_F_RM_LO];

    // ****************************************************************
    // condition check and booth step
    // ****************************************************************
    wire cond_pass;
    wire [WIDTH-1:0] step_sum;
    wire step_carry;

    bmac_cond_check u_cond (
        .cond(instr_q[`BMAC_F_COND_HI:`BMAC_F_COND_LO]),
        .flags(flags_q),
        .pass(cond_pass)
    );

    bmac_booth_step #(
        .WIDTH(WIDTH)
    ) u_step (
        .acc(acc_q),
        .mcand(mcand_q),
        .triplet({mplr_q[1:0], prev_q}),
        .sum(step_sum),
        .carry(step_carry)
    );

    wire last_step = (cnt_q == m_q);
    wire [WIDTH-1:0] final_res = force_zero_q ? {WIDTH{1'b0}} : step_sum;

    // ****************************************************************
    // register file: apb writes while idle, result writeback
    // ****************************************************************
    always @(posedge pclk) begin
        if (wb_en_q) begin
            rf_q[wb_idx_q] <= result_q;
        end else if (wr & rf_hit & ~busy) begin
            rf_q[rf_idx] <= pwdata;
        end
    end

    // ****************************************************************
    // apb answer: one wait state on every access
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= acc_ph;
            pslverr <= (wr & wr_err) | (rd & rd_err);
            if (rd) begin
                if (rf_hit) begin
                    prdata <= rf_q[rf_idx];
                end else if (hit_instr) begin
                    prdata <= instr_q;
                end else if (hit_flags) begin
                    prdata <= {flags_q, 28'h000_0000};
                end else if (hit_status) begin
                    prdata <= {19'h0_0000, m_q, 5'h00, refused_q,
                               exec_q, busy};
                end else if (hit_result) begin
                    prdata <= result_q;
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ****************************************************************
    // multiply sequencer
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            instr_q <= 32'h0000_0000;
            flags_q <= `BMAC_FLAGS_RST;
            acc_q <= {WIDTH{1'b0}};
            mcand_q <= {WIDTH{1'b0}};
            mplr_q <= {WIDTH{1'b0}};
            prev_q <= 1'b0;
            cnt_q <= 5'h00;
            m_q <= 5'h00;
            force_zero_q <= 1'b0;
            exec_q <= 1'b0;
            refused_q <= 1'b0;
            result_q <= {WIDTH{1'b0}};
            wb_en_q <= 1'b0;
            wb_idx_q <= 4'h0;
            pipe_stall <= 1'b0;
            mul_done <= 1'b0;
        end else begin
            wb_en_q <= 1'b0;
            mul_done <= 1'b0;
            if (wr & hit_instr) begin
                refused_q <= ~issue;
            end
            case (state_q)
                ST_IDLE: begin
                    if (wr & hit_flags) begin
                        flags_q <= pwdata[`BMAC_FLAGS_POS_HI:
                                          `BMAC_FLAGS_POS_LO];
                    end
                    if (issue) begin
                        // operands latched now, so rd, rn and rs may
                        // alias freely without corrupting the sum
                        instr_q <= pwdata;
                        mcand_q <= rf_q[i_rm];
                        mplr_q <= rf_q[i_rs];
                        acc_q <= pwdata[`BMAC_F_ACC] ?
                                 rf_q[i_rn] : {WIDTH{1'b0}};
                        prev_q <= 1'b0;
                        m_q <= steps_for(rf_q[i_rs]);
                        cnt_q <= `BMAC_MIN_STEPS;
                        // the destination doubles as the partial sum,
                        // so overlapping it with the first operand
                        // wipes a plain multiply; the add form is
                        // left undefined and simply computes through
                        force_zero_q <= (i_rd == i_rm)
                                        & ~pwdata[`BMAC_F_ACC];
                        wb_idx_q <= i_rd;
                        pipe_stall <= 1'b1;
                        state_q <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (cond_pass) begin
                        exec_q <= 1'b1;
                        state_q <= ST_CALC;
                    end else begin
                        // skipped: no register or flag touched
                        exec_q <= 1'b0;
                        pipe_stall <= 1'b0;
                        mul_done <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                ST_CALC: begin
                    // two multiplier bits retired per cycle
                    acc_q <= step_sum;
                    mcand_q <= {mcand_q[WIDTH-3:0], 2'b00};
                    mplr_q <= {2'b00, mplr_q[WIDTH-1:2]};
                    prev_q <= mplr_q[1];
                    cnt_q <= cnt_q + 5'h01;
                    if (last_step) begin
                        // early exit is exact: bits above are zero
                        result_q <= final_res;
                        wb_en_q <= 1'b1;
                        if (instr_q[`BMAC_F_SET]) begin
                            flags_q[`BMAC_FLAG_N] <=
                                final_res[WIDTH-1];
                            flags_q[`BMAC_FLAG_Z] <=
                                (final_res == {WIDTH{1'b0}});
                            // last adder carry, meaningless by design;
                            // overflow left alone
                            flags_q[`BMAC_FLAG_C] <= step_carry;
                        end
                        pipe_stall <= 1'b0;
                        mul_done <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    pipe_stall <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // notes
    // ****************************************************************
    // the accumulate field of a plain multiply is never read, so a
    // nonzero value there is tolerated rather than refused
    // the register file write lands one cycle after mul_done rises:
    // result_q updates on the completion edge, and wb_en_q, high in
    // the cycle mul_done is high, writes the rf on the edge after it
endmodule // bmac_top
`default_nettype wire

//--- verif/bmac_core_model.sv
// issuing side model: apb master and instruction encoder
`timescale 1ns/100ps
`default_nettype none
`include "bmac_defs.vh"

module bmac_core_model (
    input wire pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [`BMAC_ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // ****************************************************************
    // encoder and transfer
    // ****************************************************************
    function automatic logic [31:0] enc(input logic [3:0] cc, input logic a, s,
        input logic [3:0] rd, rn, rs, rm);
        // plain multiplies carry a zero accumulate field
        enc = {cc, 6'h00, a, s, rd, a ? rn : 4'h0, rs, 4'h9, rm};
    endfunction

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err, output logic to);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            to = 1'b1;
            for (n = 0; n < 20 && to; n++) begin
                @(posedge pclk);
                if (pready === 1'b1) to = 1'b0;
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // released lines must not keep looking valid
            paddr <= ~a;
            pwdata <= ~d;
        end
    endtask
endmodule // bmac_core_model
`default_nettype wire

//--- verif/bmac_top_asserts.sv
// port assertions for the booth multiply-accumulate unit
`timescale 1ns/100ps
`default_nettype none
`include "bmac_defs.vh"

module bmac_top_asserts (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`BMAC_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire pipe_stall,
    input wire mul_done
);
    // ****************************************************************
    // helpers
    // ****************************************************************
    wire acc_e = psel && penable && !pready;
    wire wr_e = acc_e && pwrite;
    wire unmapped = (paddr >= 8'h10 && paddr < 8'h40) || paddr[7];
    wire [31:0] w = pwdata;
    // reg 15 as rd, rs or rm, or as rn with the accumulate bit, is refused, so it counts as a bad word here
    wire enc_ok = w[27:22] == 6'h00 && w[7:4] == 4'h9 && w[19:16] != 4'hf
        && w[11:8] != 4'hf && w[3:0] != 4'hf && !(w[21] && w[15:12] == 4'hf);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_issue;
        wr_e && paddr == 8'h00 && !pipe_stall && enc_ok;
    endsequence
    sequence s_finish;
        mul_done && !pipe_stall;
    endsequence

    // ****************************************************************
    // properties
    // ****************************************************************
    property p_wait; acc_e |=> pready ##1 !pready; endproperty
    a_wait: assert property (p_wait) else $error("bad ready timing");
    property p_rdz; !pready |-> prdata == 32'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("read data not idle");
    property p_unm; acc_e && unmapped |=> pslverr && prdata == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped not refused");
    property p_iss; s_issue |=> pipe_stall && pready && !pslverr; endproperty
    a_iss: assert property (p_iss) else $error("issue not taken");
    property p_bad;
        wr_e && paddr == 8'h00 && !pipe_stall && !enc_ok |=> pslverr && !pipe_stall;
    endproperty
    a_bad: assert property (p_bad) else $error("bad word taken");
    property p_busy;
        wr_e && pipe_stall && (paddr == 8'h00 || paddr == 8'h04) |=> pslverr;
    endproperty
    a_busy: assert property (p_busy) else $error("busy write taken");
    property p_len; $rose(pipe_stall) |-> ##[1:17] s_finish; endproperty
    a_len: assert property (p_len) else $error("too long");
    property p_hold; pipe_stall && !mul_done |=> pipe_stall || mul_done; endproperty
    a_hold: assert property (p_hold) else $error("stall dropped");
    property p_done; mul_done |-> $past(pipe_stall) ##1 !mul_done; endproperty
    a_done: assert property (p_done) else $error("bad done pulse");
endmodule // bmac_top_asserts

bind bmac_top bmac_top_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pipe_stall(pipe_stall), .mul_done(mul_done));
`default_nettype wire

//--- verif/bmac_top_bench.sv
// self-checking bench for the booth multiply-accumulate unit
`timescale 1ns/100ps
`default_nettype none
`include "bmac_defs.vh"

module bmac_top_bench;
    logic pclk, presetn, er, to;
    wire psel, penable, pwrite, pready, pslverr, pipe_stall, mul_done;
    wire [`BMAC_ADDR_W-1:0] paddr;
    wire [31:0] pwdata, prdata;
    logic [31:0] rv;
    logic [3:0] fl;
    logic [31:0] rsv [6] = '{32'h0, 32'h1, 32'h2, 32'h1fffffff, 32'h20000000,
        32'hffffffff};
    integer n_errors = 0, cmp_count = 0, n_stall = 0, i;

    bmac_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pipe_stall(pipe_stall), .mul_done(mul_done));
    bmac_core_model core (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) if (pipe_stall === 1'b1) n_stall <= n_stall + 1;

    // ****************************************************************
    // tasks
    // ****************************************************************
    task chk(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        core.xfer(w, a, d, rv, er, to);
        if (to) begin
            n_errors++;
            print_verdict;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        bus(1'b1, a, d);
        chk("write refusal", er, e);
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e, m, input string s);
        bus(1'b0, a, 32'h0);
        chk(s, rv & m, e);
    endtask
    function automatic logic [7:0] ra(input logic [3:0] r);
        ra = {2'b01, r, 2'b00};
    endfunction
    function automatic integer exp_m(input logic [31:0] v);
        integer m;
        exp_m = 16;
        for (m = 15; m >= 2; m--) if (v < (33'h1 << (2 * m - 1))) exp_m = m;
        if (v < 2) exp_m = 1;
    endfunction
    task done_wait(input integer st);
        integer n;
        begin
            n = 0;
            #1;
            while (mul_done !== 1'b1 && n < 40) begin
                @(posedge pclk);
                #1;
                n++;
            end
            if (n >= 40) begin
                n_errors++;
                print_verdict;
            end
            chk("stall cycles", n_stall, st);
        end
    endtask
    task go(input logic [31:0] ins);
        n_stall = 0;
        wr(8'h00, ins, 1'b0);
    endtask
    task mm(input logic a, s, input logic [3:0] rd, rn, rs, rm,
        input logic [31:0] vm, vs, vn);
        logic [31:0] e;
        integer m;
        begin
            e = (rd == rm && !a) ? 32'h0 : vm * vs + (a ? vn : 32'h0);
            m = exp_m(vs);
            wr(ra(rn), vn, 1'b0);
            wr(ra(rs), vs, 1'b0);
            wr(ra(rm), vm, 1'b0);
            go(core.enc(4'he, a, s, rd, rn, rs, rm));
            done_wait(m + 1);
            rd_chk(8'h0c, e, 32'hffffffff, "result");
            rd_chk(ra(rd), e, 32'hffffffff, "dest reg");
            if (s) fl = {e[31], e == 32'h0, fl[1:0]};
            rd_chk(8'h04, {fl, 28'h0} & 32'hd0000000, 32'hd0000000, "flags");
            rd_chk(8'h08, {19'h0, m[4:0], 8'h02}, 32'hffffffff, "status");
        end
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        presetn = 1'b0;
        fl = 4'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(8'h04, 32'h0, 32'hffffffff, "flags reset");
        rd_chk(8'h08, 32'h0, 32'hffffffff, "status reset");
        rd_chk(8'h20, 32'h0, 32'hffffffff, "unmapped data");
        chk("unmapped refusal", er, 1'b1);
        wr(8'h0c, 32'h1, 1'b1);
        $display("test reset and map done");
        mm(1'b0, 1'b1, 4'h1, 4'h0, 4'h3, 4'h2, 32'hfffffff6, 32'h14, 32'h0);
        mm(1'b1, 1'b0, 4'h8, 4'h8, 4'h8, 4'h9, 32'h7, 32'h3, 32'h3);
        mm(1'b0, 1'b1, 4'ha, 4'h0, 4'hb, 4'ha, 32'h5, 32'h6, 32'h0);
        wr(8'h04, 32'h10000000, 1'b0);
        fl = 4'h1;
        mm(1'b1, 1'b1, 4'h4, 4'h5, 4'h6, 4'h7, 32'h10000, 32'h10000, 32'h5);
        $display("test operand forms done");
        for (i = 0; i < 6; i++) mm(1'b0, 1'b0, 4'h2, 4'h0, 4'h3, 4'h4, 32'h3, rsv[i], 32'h0);
        $display("test timing done");
        wr(8'h04, 32'h0, 1'b0);
        wr(ra(4'h1), 32'h55, 1'b0);
        go(core.enc(4'h0, 1'b0, 1'b1, 4'h1, 4'h0, 4'h2, 4'h3));
        done_wait(1);
        rd_chk(ra(4'h1), 32'h55, 32'hffffffff, "skipped dest");
        rd_chk(8'h08, 32'h0, 32'h3, "skipped status");
        rd_chk(8'h04, 32'h0, 32'hf0000000, "skipped flags");
        $display("test condition done");
        wr(8'h00, core.enc(4'he, 1'b0, 1'b0, 4'h1, 4'h0, 4'h2, 4'h3) ^ 32'h20, 1'b1);
        // names the program counter reg on purpose to see it refused
        wr(8'h00, core.enc(4'he, 1'b0, 1'b0, 4'hf, 4'h0, 4'h2, 4'h3), 1'b1);
        rd_chk(8'h08, 32'h4, 32'h5, "refused status");
        wr(ra(4'h3), 32'hffffffff, 1'b0);
        go(core.enc(4'he, 1'b0, 1'b0, 4'h1, 4'h0, 4'h3, 4'h2));
        wr(8'h00, core.enc(4'he, 1'b0, 1'b0, 4'h1, 4'h0, 4'h3, 4'h2), 1'b1);
        wr(8'h04, 32'hf0000000, 1'b1);
        done_wait(17);
        rd_chk(8'h04, 32'h0, 32'hf0000000, "flags kept");
        $display("test refusals done");
        print_verdict;
    end
endmodule // bmac_top_bench
`default_nettype wire
